// [rtl/ste_defines.vh]
`ifndef STE_DEFINES_VH
`define STE_DEFINES_VH

// Word framing: one serial word is twenty line bits, one bit per clock.
`define STE_WORD_BITS 20
`define STE_PHASE_LAST 5'h13
`define STE_PHASE_LOAD 5'h0D
`define STE_PHASE_RESET 5'h00

// Transmit latency window in bit times; the load phase above gives 34.
`define STE_LAT_MIN_BITS 34
`define STE_LAT_MAX_BITS 38

// Number of leading IDLE words sent after reset so the far end aligns.
`define STE_START_IDLES 2'h3

// Two-entry buffer holding {frame_valid, error_flag, data[15:0]}.
`define STE_BUF_W 18
`define STE_BUF_DEPTH 2'h2

// Special characters.
`define STE_K28_5 8'hBC
`define STE_K23_7 8'hF7
`define STE_K30_7 8'hFE
`define STE_D5_6 8'hC5
`define STE_D16_2 8'h50

// Pseudorandom generator seed (any non-zero value).
`define STE_PRBS_SEED 7'h7F

`endif

// [rtl/ste_encoder.v]
// What this block does
// RL1: Capture 16-bit transmit word every word clock; the code captures only with tx_valid_in high and the buffer not full.
// RL2: Partner presents payload with valid high, error low.
// RL3: Bit clock is ten times word clock, both edges.
// RL4: Send 20-bit encoded word, bit zero first.
// RL5: Send commas at start of transmission.
// RL6: Load-to-bit-zero latency fixed within 34..38 bits.
// RL7: Each byte has its own 8b/10b encoder.
// RL8: Standard 8b/10b with running disparity.
// RL9: Valid high, error low: both bytes data.
// RL10: Carrier extend K23.7 pair; error K30.7 pair.
// RL11: No payload sends K28.5 plus D5.6 or D16.2.
// RL12: K28.5 negative disparity is 0011111010.
// RL13: Whole IDLE pair fits one word period.
// RL14: PRBS select feeds 2^7-1 pattern into serializer.
// RL15: PRBS mode ignores word and controls.
// RL16: Partner holds frame valid through frame only.
// RL17: Second IDLE character restores negative disparity.
// RL18: PRBS is x^7+x^6+1, never all zero.
// RL19: Low byte is encoded and sent first.
`timescale 1ns/10ps
`include "ste_defines.vh"

module ste_encoder (
	// Clock and reset.
	input wire sys_clk_in,
	input wire rst_in,
	// Parallel transmit side from the protocol device.
	input wire [15:0] tx_data_in,
	input wire tx_frame_valid_in,
	input wire tx_error_flag_in,
	input wire tx_valid_in,
	output wire tx_ready_out,
	output wire tx_ref_word_clock_out,
	// Test mode.
	input wire prbs_test_select_in,
	// Serial line side.
	input wire ser_ready_in,
	output reg ser_data_out,
	output reg ser_bitclk_out
);

	localparam ST_START = 1'b0;
	localparam ST_RUN = 1'b1;

	reg [4:0] phase_r;
	reg state_r;
	reg [1:0] start_cnt_r;
	reg rd_r;
	reg [19:0] enc_r;
	reg [19:0] shift_r;
	reg [6:0] prbs_r;
	reg [`STE_BUF_W-1:0] buf_mem [0:1];
	reg buf_wp_r;
	reg buf_rp_r;
	reg [1:0] buf_cnt_r;

	wire word_tick;
	wire load_tick;
	wire buf_full;
	wire buf_empty;
	wire push;
	wire pop;
	wire [`STE_BUF_W-1:0] head;
	wire [22:0] prbs_step;

	reg lo_k;
	reg hi_k;
	reg [7:0] lo_b;
	reg [7:0] hi_b;
	reg is_idle;
	wire [10:0] e_lo;
	wire [10:0] e_hi;
	wire [7:0] hi_b_fin;

	// Six-bit sub-block in negative-disparity form, a in the msb.
	function [5:0] ste_t6;
		input [4:0] x;
		input k;
		begin
			case (x)
				5'd0: ste_t6 = 6'b100111;
				5'd1: ste_t6 = 6'b011101;
				5'd2: ste_t6 = 6'b101101;
				5'd3: ste_t6 = 6'b110001;
				5'd4: ste_t6 = 6'b110101;
				5'd5: ste_t6 = 6'b101001;
				5'd6: ste_t6 = 6'b011001;
				5'd7: ste_t6 = 6'b111000;
				5'd8: ste_t6 = 6'b111001;
				5'd9: ste_t6 = 6'b100101;
				5'd10: ste_t6 = 6'b010101;
				5'd11: ste_t6 = 6'b110100;
				5'd12: ste_t6 = 6'b001101;
				5'd13: ste_t6 = 6'b101100;
				5'd14: ste_t6 = 6'b011100;
				5'd15: ste_t6 = 6'b010111;
				5'd16: ste_t6 = 6'b011011;
				5'd17: ste_t6 = 6'b100011;
				5'd18: ste_t6 = 6'b010011;
				5'd19: ste_t6 = 6'b110010;
				5'd20: ste_t6 = 6'b001011;
				5'd21: ste_t6 = 6'b101010;
				5'd22: ste_t6 = 6'b011010;
				5'd23: ste_t6 = 6'b111010;
				5'd24: ste_t6 = 6'b110011;
				5'd25: ste_t6 = 6'b100110;
				5'd26: ste_t6 = 6'b010110;
				5'd27: ste_t6 = 6'b110110;
				5'd28: ste_t6 = k ? 6'b001111 : 6'b001110;
				5'd29: ste_t6 = 6'b101110;
				5'd30: ste_t6 = 6'b011110;
				default: ste_t6 = 6'b101011;
			endcase
		end
	endfunction

	// Four-bit sub-block in negative-disparity form, f in the msb.
	function [3:0] ste_t4;
		input [2:0] y;
		input k;
		input alt;
		begin
			case (y)
				3'd0: ste_t4 = 4'b1011;
				3'd1: ste_t4 = k ? 4'b0110 : 4'b1001;
				3'd2: ste_t4 = k ? 4'b1010 : 4'b0101;
				3'd3: ste_t4 = 4'b1100;
				3'd4: ste_t4 = 4'b1101;
				3'd5: ste_t4 = k ? 4'b0101 : 4'b1010;
				3'd6: ste_t4 = k ? 4'b1001 : 4'b0110;
				default: ste_t4 = (k || alt) ? 4'b0111 : 4'b1110;
			endcase
		end
	endfunction

	function [2:0] ste_ones;
		input [5:0] v;
		integer i;
		begin
			ste_ones = 3'd0;
			for (i = 0; i < 6; i = i + 1)
				ste_ones = ste_ones + {2'b00, v[i]};
		end
	endfunction

	// Returns {disparity after, ten-bit character with a in bit 0}; rd high means positive.
	function [10:0] ste_enc;
		input k;
		input [7:0] b;
		input rd;
		reg [5:0] c6;
		reg [3:0] c4;
		reg r1;
		reg r2;
		reg alt;
		reg [9:0] w;
		integer i;
		begin
			c6 = ste_t6(b[4:0], k);
			r1 = rd;
			if (ste_ones(c6) != 3'd3) // [RL8]
			begin
				if (rd)
					c6 = ~c6;
				r1 = ~rd;
			end
			else if (rd && !k && b[4:0] == 5'd7)
				c6 = ~c6;
			alt = (!r1 && (b[4:0] == 5'd17 || b[4:0] == 5'd18 || b[4:0] == 5'd20)) ||
				(r1 && (b[4:0] == 5'd11 || b[4:0] == 5'd13 || b[4:0] == 5'd14));
			c4 = ste_t4(b[7:5], k, alt);
			r2 = r1;
			if (ste_ones({2'b00, c4}) != 3'd2) // [RL8]
			begin
				if (r1)
					c4 = ~c4;
				r2 = ~r1;
			end
			else if (r1 && (k || b[7:5] == 3'd3)) // [RL8] [RL12]
				c4 = ~c4;
			w = {c6, c4};
			for (i = 0; i < 10; i = i + 1)
				ste_enc[i] = w[9-i]; // [RL4]
			ste_enc[10] = r2;
		end
	endfunction

	// Advances the generator sixteen steps; returns {new state, sixteen bits}.
	function [22:0] ste_prbs16;
		input [6:0] s;
		reg [6:0] t;
		reg [15:0] o;
		integer i;
		begin
			t = (s == 7'h00) ? `STE_PRBS_SEED : s; // [RL18]
			o = 16'h0000;
			for (i = 0; i < 16; i = i + 1)
			begin
				o[i] = t[6];
				t = {t[5:0], t[6] ^ t[5]}; // [RL18]
			end
			ste_prbs16 = {t, o};
		end
	endfunction

	// One word period is twenty clocks; the line carries one bit per clock.
	assign word_tick = (phase_r == `STE_PHASE_LAST);
	assign load_tick = (phase_r == `STE_PHASE_LOAD);
	assign tx_ref_word_clock_out = word_tick;

	assign buf_full = (buf_cnt_r == `STE_BUF_DEPTH);
	assign buf_empty = (buf_cnt_r == 2'h0);
	assign tx_ready_out = !buf_full;
	assign push = word_tick && tx_valid_in && !buf_full; // [RL1]
	// Draining stops while the line is not ready, so the buffer really fills.
	assign pop = word_tick && !buf_empty && ser_ready_in && state_r == ST_RUN;
	assign head = buf_mem[buf_rp_r];
	assign prbs_step = ste_prbs16(prbs_r);

	always @*
	begin
		lo_k = 1'b0;
		hi_k = 1'b0;
		lo_b = head[7:0]; // [RL19]
		hi_b = head[15:8];
		is_idle = 1'b0;
		if (prbs_test_select_in) // [RL15]
		begin
			lo_b = prbs_step[7:0]; // [RL14]
			hi_b = prbs_step[15:8];
		end
		else if (!pop || {head[17], head[16]} == 2'b00) // [RL5] [RL11]
		begin
			is_idle = 1'b1;
			lo_k = 1'b1;
			lo_b = `STE_K28_5; // [RL12]
		end
		else if (head[16]) // [RL10]
		begin
			lo_k = 1'b1;
			hi_k = 1'b1;
			lo_b = head[17] ? `STE_K30_7 : `STE_K23_7;
			hi_b = lo_b;
		end
		// Frame valid high with error low leaves both bytes as data. [RL9] [RL2] [RL16]
	end

	// Separate encoders per byte, chained through running disparity. [RL7]
	assign e_lo = ste_enc(lo_k, lo_b, rd_r);
	assign hi_b_fin = is_idle ? (e_lo[10] ? `STE_D16_2 : `STE_D5_6) : hi_b; // [RL17]
	assign e_hi = ste_enc(hi_k, hi_b_fin, e_lo[10]);

	always @(posedge sys_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			phase_r <= `STE_PHASE_RESET;
			state_r <= ST_START;
			start_cnt_r <= `STE_START_IDLES;
			rd_r <= 1'b0;
			enc_r <= 20'h0_0000;
			prbs_r <= `STE_PRBS_SEED;
		end
		else
		begin
			phase_r <= word_tick ? `STE_PHASE_RESET : phase_r + 5'h01;
			if (word_tick)
			begin
				enc_r <= {e_hi[9:0], e_lo[9:0]}; // [RL13] [RL19]
				rd_r <= e_hi[10]; // [RL8]
				if (prbs_test_select_in)
					prbs_r <= prbs_step[22:16]; // [RL14]
				case (state_r)
					ST_START:
					begin
						if (start_cnt_r == 2'h1)
							state_r <= ST_RUN;
						start_cnt_r <= start_cnt_r - 2'h1;
					end
					default:
						state_r <= ST_RUN;
				endcase
			end
		end
	end

	// Two-entry buffer between the capture edge and the encoders.
	always @(posedge sys_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			buf_wp_r <= 1'b0;
			buf_rp_r <= 1'b0;
			buf_cnt_r <= 2'h0;
		end
		else
		begin
			if (push)
				buf_wp_r <= ~buf_wp_r;
			if (pop)
				buf_rp_r <= ~buf_rp_r;
			if (push && !pop)
				buf_cnt_r <= buf_cnt_r + 2'h1;
			else if (pop && !push)
				buf_cnt_r <= buf_cnt_r - 2'h1;
		end
	end

	always @(posedge sys_clk_in)
	begin
		if (push)
			buf_mem[buf_wp_r] <= {tx_frame_valid_in, tx_error_flag_in, tx_data_in}; // [RL1]
	end

	// The load phase is fixed, so latency cannot drift once running. [RL6]
	always @(posedge sys_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			shift_r <= 20'h0_0000;
			ser_data_out <= 1'b0;
			ser_bitclk_out <= 1'b0;
		end
		else
		begin
			ser_bitclk_out <= ~ser_bitclk_out; // [RL3]
			if (load_tick)
			begin
				ser_data_out <= enc_r[0]; // [RL4] [RL6]
				shift_r <= {1'b0, enc_r[19:1]};
			end
			else
			begin
				ser_data_out <= shift_r[0]; // [RL3]
				shift_r <= {1'b0, shift_r[19:1]};
			end
		end
	end

endmodule // ste_encoder

// [bench/ste_enc_assertions.sv]
`timescale 1ns/10ps
module ste_enc_assertions (
	// Clock and reset.
	input wire sys_clk_in,
	input wire rst_in,
	// Watched ports.
	input wire tx_valid_in,
	input wire tx_ready_out,
	input wire tx_ref_word_clock_out,
	input wire ser_data_out,
	input wire ser_bitclk_out
);
	reg [1:0] ticks_r;
	// The line is only judged from the second word tick, since the shifter is quiet until the first idle word is loaded.
	always @(posedge sys_clk_in or posedge rst_in)
	begin
		if (rst_in)
			ticks_r <= 2'h0;
		else if (tx_ref_word_clock_out && ticks_r != 2'h2)
			ticks_r <= ticks_r + 2'h1;
	end
	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (rst_in);
	AST_TICK_PERIOD: assert property (tx_ref_word_clock_out |-> ##20 tx_ref_word_clock_out)
		else $error("word tick period wrong");
	AST_TICK_PULSE: assert property (tx_ref_word_clock_out |=> (!tx_ref_word_clock_out) [*8])
		else $error("word tick too long");
	AST_BITCLK_TOGGLE: assert property (1'b1 |=> ser_bitclk_out != $past(ser_bitclk_out))
		else $error("bit clock did not toggle");
	AST_BITCLK_TICK: assert property (tx_ref_word_clock_out |-> ##20 ser_bitclk_out == $past(ser_bitclk_out, 20))
		else $error("bit clock not locked to word tick");
	AST_READY_FALL: assert property ($fell(tx_ready_out) |-> $past(tx_ref_word_clock_out && tx_valid_in))
		else $error("ready fell without a take");
	AST_READY_RISE: assert property ($rose(tx_ready_out) |-> $past(tx_ref_word_clock_out))
		else $error("ready rose off a word tick");
	AST_RUN_ONE: assert property ((ticks_r == 2'h2 && ser_data_out) [*5] |=> !ser_data_out)
		else $error("run of ones too long");
	AST_RUN_ZERO: assert property ((ticks_r == 2'h2 && !ser_data_out) [*5] |=> ser_data_out)
		else $error("run of zeros too long");
	COV_TAKE: cover property (tx_ref_word_clock_out && tx_valid_in && tx_ready_out);
	COV_FULL: cover property (tx_ref_word_clock_out && !tx_ready_out);
	COV_BACK: cover property (tx_ready_out && tx_valid_in && tx_ref_word_clock_out ##20 tx_valid_in);
endmodule // ste_enc_assertions

// [bench/ste_proto_model.sv]
`timescale 1ns/10ps
module ste_proto_model (
	// Clock and word timing.
	input wire sys_clk_in,
	input wire tick_in,
	input wire ready_in,
	// Transmit request.
	output reg [15:0] data_out,
	output reg fv_out,
	output reg er_out,
	output reg valid_out
);
	initial
	begin
		data_out = 16'hA5A5;
		fv_out = 1'b0;
		er_out = 1'b0;
		valid_out = 1'b0;
	end
	// Holds the word until the tick edge that takes it, then scrambles the bus so no stale word is seen.
	task send(input [15:0] d, input fv, input er);
		integer i;
		begin
			@(negedge sys_clk_in);
			data_out = d;
			fv_out = fv;
			er_out = er;
			valid_out = 1'b1;
			i = 0;
			while (!(tick_in && ready_in) && i < 100)
			begin
				@(negedge sys_clk_in);
				i = i + 1;
			end
			@(negedge sys_clk_in);
			valid_out = 1'b0;
			fv_out = 1'b0;
			data_out = ~d;
		end
	endtask
endmodule // ste_proto_model

// [bench/tb_top.sv]
`timescale 1ns/10ps
module tb_top;
	reg sys_clk_in;
	reg rst_in;
	reg prbs_test_select_in;
	reg ser_ready_in;
	wire [15:0] tx_data_in;
	wire tx_frame_valid_in;
	wire tx_error_flag_in;
	wire tx_valid_in;
	wire tx_ready_out;
	wire tx_ref_word_clock_out;
	wire ser_data_out;
	wire ser_bitclk_out;
	integer n_mismatch;
	integer checked;
	reg [19:0] w;
	ste_encoder DUT (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .tx_data_in(tx_data_in),
		.tx_frame_valid_in(tx_frame_valid_in), .tx_error_flag_in(tx_error_flag_in), .tx_valid_in(tx_valid_in),
		.tx_ready_out(tx_ready_out), .tx_ref_word_clock_out(tx_ref_word_clock_out),
		.prbs_test_select_in(prbs_test_select_in), .ser_ready_in(ser_ready_in),
		.ser_data_out(ser_data_out), .ser_bitclk_out(ser_bitclk_out));
	ste_proto_model prt (.sys_clk_in(sys_clk_in), .tick_in(tx_ref_word_clock_out), .ready_in(tx_ready_out),
		.data_out(tx_data_in), .fv_out(tx_frame_valid_in), .er_out(tx_error_flag_in), .valid_out(tx_valid_in));
	initial
	begin
		sys_clk_in = 1'b0;
		forever #10 sys_clk_in = ~sys_clk_in;
	end
	task summarize;
		begin
			$display("checked %0d n_mismatch %0d", checked, n_mismatch);
			if (n_mismatch == 0 && checked > 0)
				$display("ALL TESTS PASSED");
			else
				$display("TESTS FAILED");
			$finish;
		end
	endtask
	// Characters are held with the first line bit in bit 0; either disparity form may be given.
	task chk(input string nm, input [9:0] got, input [9:0] e0, input [9:0] e1);
		begin
			checked = checked + 1;
			if (got !== e0 && got !== e1)
			begin
				n_mismatch = n_mismatch + 1;
				$display("unexpected %s exp %h seen %h", nm, e0, got);
			end
		end
	endtask
	// Captures the line word popped at the next tick edge; it starts 14 edges after the pop.
	task get_word;
		integer i;
		begin
			i = 0;
			@(negedge sys_clk_in);
			while (!tx_ref_word_clock_out && i < 40)
			begin
				@(negedge sys_clk_in);
				i = i + 1;
			end
			if (i >= 40)
			begin
				n_mismatch = n_mismatch + 1;
				$display("unexpected word_tick exp 1 seen 0");
			end
			repeat (15) @(posedge sys_clk_in);
			get_more;
		end
	endtask
	// Captures the twenty line bits that follow at once, so a word popped back to back is not missed.
	task get_more;
		integer i;
		begin
			for (i = 0; i < 20; i = i + 1)
			begin
				@(negedge sys_clk_in);
				w[i] = ser_data_out;
			end
		end
	endtask
	task t_start;
		integer k;
		begin
			for (k = 0; k < 3; k = k + 1)
			begin
				get_word;
				chk("idle_low", w[9:0], 10'h17C, 10'h17C);
				chk("idle_high", w[19:10], 10'h289, 10'h289);
			end
		end
	endtask
	task t_mode(input fv, input er, input [15:0] d, input [9:0] l0, l1, h0, h1);
		begin
			prt.send(d, fv, er);
			get_word;
			chk("low_char", w[9:0], l0, l1);
			chk("high_char", w[19:10], h0, h1);
		end
	endtask
	task t_full;
		begin
			ser_ready_in = 1'b0;
			prt.send(16'h50C5, 1'b1, 1'b0);
			prt.send(16'h0000, 1'b1, 1'b1);
			chk("ready", {9'h000, tx_ready_out}, 10'h000, 10'h000);
			get_word;
			chk("stall_low", w[9:0], 10'h17C, 10'h283);
			ser_ready_in = 1'b1;
			get_word;
			chk("first_low", w[9:0], 10'h1A5, 10'h1A5);
			get_more;
			chk("second_low", w[9:0], 10'h05E, 10'h3A1);
			chk("second_high", w[19:10], 10'h05E, 10'h3A1);
		end
	endtask
	task t_prbs;
		begin
			prbs_test_select_in = 1'b1;
			prt.send(16'h0000, 1'b0, 1'b1);
			get_word;
			checked = checked + 1;
			if (w[9:0] === 10'h17C || w[9:0] === 10'h283 || w[9:0] === 10'h057 || w[9:0] === 10'h3A8)
			begin
				n_mismatch = n_mismatch + 1;
				$display("unexpected prbs_low exp data seen %h", w[9:0]);
			end
			prbs_test_select_in = 1'b0;
		end
	endtask
	initial
	begin
		n_mismatch = 0;
		checked = 0;
		rst_in = 1'b1;
		prbs_test_select_in = 1'b0;
		ser_ready_in = 1'b1;
		repeat (5) @(negedge sys_clk_in);
		rst_in = 1'b0;
		t_start;
		t_mode(1'b1, 1'b0, 16'h50C5, 10'h1A5, 10'h1A5, 10'h289, 10'h2B6);
		t_mode(1'b0, 1'b1, 16'h1234, 10'h057, 10'h3A8, 10'h057, 10'h3A8);
		t_mode(1'b1, 1'b1, 16'h1234, 10'h05E, 10'h3A1, 10'h05E, 10'h3A1);
		t_mode(1'b0, 1'b0, 16'h1234, 10'h17C, 10'h283, 10'h289, 10'h1A5);
		t_full;
		t_prbs;
		summarize;
	end
	initial
	begin
		#100000;
		n_mismatch = n_mismatch + 1;
		summarize;
	end
endmodule // tb_top
bind ste_encoder ste_enc_assertions chk_i (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .tx_valid_in(tx_valid_in),
	.tx_ready_out(tx_ready_out), .tx_ref_word_clock_out(tx_ref_word_clock_out),
	.ser_data_out(ser_data_out), .ser_bitclk_out(ser_bitclk_out));
